/* core/fpsc_cmp_enc.sv */
// Comparison result encoder and conditional-move condition evaluator
`default_nettype none
module fpsc_cmp_enc (
    input wire fpsc_pkg::fpsc_cmp_t cmp_i,
    input wire fpsc_pkg::fpsc_cond_t cond_i,
    input wire logic [7:0] int_flags_i,
    output logic [3:0] cc_o,
    output logic [7:0] flag_val_o,
    output logic [7:0] flag_mask_o,
    output logic move_take_o
);
    import fpsc_pkg::*;

    logic carry;
    logic parity;
    logic zero;
    logic hit;

    // Compare outcome onto C3/C2/C0; C1 is left to the caller
    always_comb begin
        cc_o = '0;
        cc_o[FPSC_CC0] = (cmp_i == FPSC_CMP_LT) || (cmp_i == FPSC_CMP_UNORD);
        cc_o[FPSC_CC2] = (cmp_i == FPSC_CMP_UNORD);
        cc_o[FPSC_CC3] = (cmp_i == FPSC_CMP_EQ) || (cmp_i == FPSC_CMP_UNORD);
    end

    // Same outcome straight into zero/parity/carry, other flag bits untouched
    always_comb begin
        flag_val_o = '0;
        flag_mask_o = '0;
        flag_val_o[FPSC_ZERO_BIT] = cc_o[FPSC_CC3];
        flag_val_o[FPSC_PARITY_BIT] = cc_o[FPSC_CC2];
        flag_val_o[FPSC_CARRY_BIT] = cc_o[FPSC_CC0];
        flag_mask_o[FPSC_ZERO_BIT] = 1'b1;
        flag_mask_o[FPSC_PARITY_BIT] = 1'b1;
        flag_mask_o[FPSC_CARRY_BIT] = 1'b1;
    end

    // Condition test on the integer flags latched with the request; high select bit negates
    always_comb begin
        carry = int_flags_i[FPSC_CARRY_BIT];
        parity = int_flags_i[FPSC_PARITY_BIT];
        zero = int_flags_i[FPSC_ZERO_BIT];
        case (cond_i)
            FPSC_CND_B, FPSC_CND_NB: hit = carry;
            FPSC_CND_E, FPSC_CND_NE: hit = zero;
            FPSC_CND_BE, FPSC_CND_NBE: hit = carry | zero;
            default: hit = parity;
        endcase
        move_take_o = hit ^ cond_i[2];
    end
endmodule
`default_nettype wire

/* core/fpsc_pkg.sv */
// Shared constants, enumerations and request/response carriers of the status/control block
`default_nettype none
package fpsc_pkg;
    // Status word field positions
    localparam int unsigned FPSC_EXC_W = 6;
    localparam int unsigned FPSC_EXC_INVALID = 0;
    localparam int unsigned FPSC_EXC_INEXACT = 5;
    localparam int unsigned FPSC_SFAULT_BIT = 6;
    localparam int unsigned FPSC_SUMMARY_BIT = 7;
    localparam int unsigned FPSC_C0_BIT = 8;
    localparam int unsigned FPSC_C1_BIT = 9;
    localparam int unsigned FPSC_C2_BIT = 10;
    localparam int unsigned FPSC_TOP_LSB = 11;
    localparam int unsigned FPSC_TOP_W = 3;
    localparam int unsigned FPSC_C3_BIT = 14;
    localparam int unsigned FPSC_BUSY_BIT = 15;
    localparam int unsigned FPSC_WORD_W = 16;
    // Condition code vector index (cc[0]=C0 .. cc[3]=C3)
    localparam int unsigned FPSC_CC0 = 0;
    localparam int unsigned FPSC_CC1 = 1;
    localparam int unsigned FPSC_CC2 = 2;
    localparam int unsigned FPSC_CC3 = 3;
    // Control word: mask field and value after initialise/save
    localparam int unsigned FPSC_MASK_LSB = 0;
    localparam logic [15:0] FPSC_CTRL_INIT = 16'h037f;
    // Integer flags register, low byte
    localparam int unsigned FPSC_BYTE_W = 8;
    localparam int unsigned FPSC_CARRY_BIT = 0;
    localparam int unsigned FPSC_PARITY_BIT = 2;
    localparam int unsigned FPSC_ZERO_BIT = 6;
    localparam int unsigned FPSC_ACC_HI_LSB = 8;

    typedef enum logic [4:0] {
        FPSC_OP_NOP = 5'h00,
        FPSC_OP_COMPARE = 5'h01,
        FPSC_OP_COMPARE_SET = 5'h02,
        FPSC_OP_EXAMINE = 5'h03,
        FPSC_OP_PREM = 5'h04,
        FPSC_OP_ARITH = 5'h05,
        FPSC_OP_TRIG = 5'h06,
        FPSC_OP_LOADLIKE = 5'h07,
        FPSC_OP_RESTORE = 5'h08,
        FPSC_OP_LOAD_ENV = 5'h09,
        FPSC_OP_INIT = 5'h0a,
        FPSC_OP_SAVE = 5'h0b,
        FPSC_OP_CLEAR_EXC = 5'h0c,
        FPSC_OP_STORE_STATUS = 5'h0d,
        FPSC_OP_FLAGS_LOAD = 5'h0e,
        FPSC_OP_COND_MOVE = 5'h0f,
        FPSC_OP_LOAD_CTRL = 5'h10,
        FPSC_OP_STORE_CTRL = 5'h11
    } fpsc_op_t;

    typedef enum logic [1:0] {
        FPSC_CMP_GT = 2'h0,
        FPSC_CMP_LT = 2'h1,
        FPSC_CMP_EQ = 2'h2,
        FPSC_CMP_UNORD = 2'h3
    } fpsc_cmp_t;

    typedef enum logic [2:0] {
        FPSC_CND_B = 3'h0,
        FPSC_CND_E = 3'h1,
        FPSC_CND_BE = 3'h2,
        FPSC_CND_U = 3'h3,
        FPSC_CND_NB = 3'h4,
        FPSC_CND_NE = 3'h5,
        FPSC_CND_NBE = 3'h6,
        FPSC_CND_NU = 3'h7
    } fpsc_cond_t;

    // Gray order along IDLE -> EXEC -> DONE
    typedef enum logic [1:0] {
        FPSC_ST_IDLE = 2'h0,
        FPSC_ST_EXEC = 2'h1,
        FPSC_ST_DONE = 2'h3
    } fpsc_state_t;

    typedef struct packed {
        fpsc_op_t op;
        logic [5:0] exc;
        logic stack_fault;
        logic stack_ovf;
        logic round_up;
        logic range_err;
        logic reduce_incomplete;
        logic [2:0] quot;
        fpsc_cmp_t cmp;
        logic [2:0] exam_class;
        logic exam_sign;
        fpsc_cond_t cond;
        logic [7:0] int_flags;
        logic [15:0] acc;
        logic to_acc;
        logic [15:0] img_status;
        logic [15:0] img_ctrl;
        logic top_we;
        logic [2:0] top_val;
    } fpsc_req_t;

    typedef struct packed {
        logic acc_we;
        logic [15:0] acc;
        logic iflag_we;
        logic [7:0] iflag_mask;
        logic [7:0] iflag_val;
        logic mem_status_we;
        logic [15:0] mem_status;
        logic mem_ctrl_we;
        logic [15:0] mem_ctrl;
        logic move_take;
    } fpsc_rsp_t;
endpackage
`default_nettype wire

/* core/fpsc_status_ctrl.sv */
// Status word, control word and condition-code paths of the floating-point unit
`default_nettype none
module fpsc_status_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire fpsc_pkg::fpsc_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output fpsc_pkg::fpsc_rsp_t rsp_o,
    output logic [15:0] status_word_o,
    output logic [15:0] control_word_o,
    output logic summary_o
);
    import fpsc_pkg::*;

    fpsc_state_t state_r;
    fpsc_state_t state_nxt;
    fpsc_req_t req_r;
    fpsc_req_t req_nxt;

    logic [FPSC_EXC_W-1:0] flags_r;
    logic [FPSC_EXC_W-1:0] flags_nxt;
    logic [FPSC_EXC_W-1:0] flags_keep;
    logic [FPSC_EXC_W-1:0] exc_hit;
    logic stack_fault_r;
    logic stack_fault_nxt;
    logic summary_r;
    logic summary_nxt;
    logic [3:0] cc_r;
    logic [3:0] cc_nxt;
    logic [FPSC_TOP_W-1:0] top_r;
    logic [FPSC_TOP_W-1:0] top_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    fpsc_rsp_t rsp_r;
    fpsc_rsp_t rsp_nxt;

    logic [15:0] status_w;
    logic [3:0] cmp_cc;
    logic [7:0] cmp_flag_val;
    logic [7:0] cmp_flag_mask;
    logic cmp_move_take;
    logic exec;
    logic inexact_now;

    // Compare encoding and move-condition test live in a small helper
    fpsc_cmp_enc u_cmp_enc (
        .cmp_i(req_r.cmp),
        .cond_i(req_r.cond),
        .int_flags_i(req_r.int_flags),
        .cc_o(cmp_cc),
        .flag_val_o(cmp_flag_val),
        .flag_mask_o(cmp_flag_mask),
        .move_take_o(cmp_move_take)
    );

    // Sequencer: one request at a time, answered two cycles after it is taken
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        case (state_r)
            FPSC_ST_IDLE: begin
                if (req_valid_i) begin
                    req_nxt = req_i;
                    state_nxt = FPSC_ST_EXEC;
                end
            end
            FPSC_ST_EXEC: begin
                state_nxt = FPSC_ST_DONE;
            end
            FPSC_ST_DONE: begin
                state_nxt = FPSC_ST_IDLE;
            end
            default: begin
                state_nxt = FPSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= FPSC_ST_IDLE;
            req_r <= '0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
        end
    end

    assign req_ready_o = (state_r == FPSC_ST_IDLE);
    assign rsp_valid_o = (state_r == FPSC_ST_DONE);
    assign exec = (state_r == FPSC_ST_EXEC);
    assign inexact_now = req_r.exc[FPSC_EXC_INEXACT];

    // Status word assembled from the architectural flops
    always_comb begin
        status_w = '0;
        status_w[FPSC_EXC_W-1:0] = flags_r;
        status_w[FPSC_SFAULT_BIT] = stack_fault_r;
        status_w[FPSC_SUMMARY_BIT] = summary_r;
        status_w[FPSC_C0_BIT] = cc_r[FPSC_CC0];
        status_w[FPSC_C1_BIT] = cc_r[FPSC_CC1];
        status_w[FPSC_C2_BIT] = cc_r[FPSC_CC2];
        status_w[FPSC_TOP_LSB +: FPSC_TOP_W] = top_r;
        status_w[FPSC_C3_BIT] = cc_r[FPSC_CC3];
        status_w[FPSC_BUSY_BIT] = summary_r;
    end

    // Architectural state update, done once per request in the EXEC cycle
    always_comb begin
        cc_nxt = cc_r;
        top_nxt = top_r;
        ctrl_nxt = ctrl_r;
        stack_fault_nxt = stack_fault_r;
        flags_keep = flags_r;
        rsp_nxt = rsp_r;
        if (exec) begin
            rsp_nxt = '0;
            if (req_r.top_we) begin
                top_nxt = req_r.top_val;
            end
            case (req_r.op)
                FPSC_OP_COMPARE: begin
                    cc_nxt = cmp_cc;
                    cc_nxt[FPSC_CC1] = 1'b0;
                end
                FPSC_OP_COMPARE_SET: begin
                    cc_nxt[FPSC_CC1] = 1'b0;
                    rsp_nxt.iflag_we = 1'b1;
                    rsp_nxt.iflag_mask = cmp_flag_mask;
                    rsp_nxt.iflag_val = cmp_flag_val;
                end
                FPSC_OP_EXAMINE: begin
                    cc_nxt[FPSC_CC3] = req_r.exam_class[2];
                    cc_nxt[FPSC_CC2] = req_r.exam_class[1];
                    cc_nxt[FPSC_CC0] = req_r.exam_class[0];
                    cc_nxt[FPSC_CC1] = req_r.exam_sign;
                end
                FPSC_OP_PREM: begin
                    cc_nxt[FPSC_CC2] = req_r.reduce_incomplete;
                    if (!req_r.reduce_incomplete) begin
                        cc_nxt[FPSC_CC0] = req_r.quot[2];
                        cc_nxt[FPSC_CC3] = req_r.quot[1];
                        cc_nxt[FPSC_CC1] = req_r.quot[0];
                    end
                end
                FPSC_OP_ARITH: begin
                    cc_nxt[FPSC_CC1] = inexact_now & req_r.round_up;
                end
                FPSC_OP_TRIG: begin
                    cc_nxt[FPSC_CC2] = req_r.range_err;
                    // C1 is undefined out of range, so it is simply left alone
                    if (!req_r.range_err) begin
                        cc_nxt[FPSC_CC1] = inexact_now & req_r.round_up;
                    end
                end
                FPSC_OP_LOADLIKE: begin
                    cc_nxt[FPSC_CC1] = 1'b0;
                end
                FPSC_OP_RESTORE, FPSC_OP_LOAD_ENV: begin
                    flags_keep = req_r.img_status[FPSC_EXC_W-1:0];
                    stack_fault_nxt = req_r.img_status[FPSC_SFAULT_BIT];
                    cc_nxt[FPSC_CC0] = req_r.img_status[FPSC_C0_BIT];
                    cc_nxt[FPSC_CC1] = req_r.img_status[FPSC_C1_BIT];
                    cc_nxt[FPSC_CC2] = req_r.img_status[FPSC_C2_BIT];
                    cc_nxt[FPSC_CC3] = req_r.img_status[FPSC_C3_BIT];
                    top_nxt = req_r.img_status[FPSC_TOP_LSB +: FPSC_TOP_W];
                    ctrl_nxt = req_r.img_ctrl;
                end
                FPSC_OP_INIT, FPSC_OP_SAVE: begin
                    // Save hands out the old words before reinitialising
                    rsp_nxt.mem_status_we = (req_r.op == FPSC_OP_SAVE);
                    rsp_nxt.mem_status = status_w;
                    rsp_nxt.mem_ctrl_we = (req_r.op == FPSC_OP_SAVE);
                    rsp_nxt.mem_ctrl = ctrl_r;
                    flags_keep = '0;
                    stack_fault_nxt = 1'b0;
                    cc_nxt = '0;
                    top_nxt = '0;
                    ctrl_nxt = FPSC_CTRL_INIT;
                end
                FPSC_OP_CLEAR_EXC: begin
                    flags_keep = '0;
                    stack_fault_nxt = 1'b0;
                end
                FPSC_OP_STORE_STATUS: begin
                    rsp_nxt.acc_we = req_r.to_acc;
                    rsp_nxt.acc = status_w;
                    rsp_nxt.mem_status_we = !req_r.to_acc;
                    rsp_nxt.mem_status = status_w;
                end
                FPSC_OP_FLAGS_LOAD: begin
                    rsp_nxt.iflag_we = 1'b1;
                    rsp_nxt.iflag_mask = '1;
                    rsp_nxt.iflag_val = req_r.acc[FPSC_ACC_HI_LSB +: FPSC_BYTE_W];
                end
                FPSC_OP_COND_MOVE: begin
                    rsp_nxt.move_take = cmp_move_take;
                end
                FPSC_OP_LOAD_CTRL: begin
                    ctrl_nxt = req_r.img_ctrl;
                end
                FPSC_OP_STORE_CTRL: begin
                    rsp_nxt.mem_ctrl_we = 1'b1;
                    rsp_nxt.mem_ctrl = ctrl_r;
                end
                default: begin
                    cc_nxt = cc_r;
                end
            endcase
            // Stack fault is applied last so it beats any clear in the same request
            if (req_r.stack_fault) begin
                stack_fault_nxt = 1'b1;
                cc_nxt[FPSC_CC1] = req_r.stack_ovf;
            end
        end
    end

    // Per-flag sticky set: a new exception wins over a clear or image load
    genvar gi;
    generate
        for (gi = 0; gi < FPSC_EXC_W; gi++) begin : g_flag
            if (gi == FPSC_EXC_INVALID) begin : g_inv
                // Stack fault always reports as an invalid operation too
                assign exc_hit[gi] = exec & (req_r.exc[gi] | req_r.stack_fault);
            end else begin : g_oth
                assign exc_hit[gi] = exec & req_r.exc[gi];
            end
            // Masked or not, the flag records the event
            assign flags_nxt[gi] = flags_keep[gi] | exc_hit[gi];
        end
    endgenerate

    // Summary follows unmasked flags only; a set mask bit keeps its own flag out of it
    always_comb begin
        summary_nxt = |(flags_nxt & ~ctrl_nxt[FPSC_MASK_LSB +: FPSC_EXC_W]);
    end

    // Architectural registers; invalid-operand events never touch the fault bit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flags_r <= '0;
            stack_fault_r <= 1'b0;
            summary_r <= 1'b0;
            cc_r <= '0;
            top_r <= '0;
            ctrl_r <= FPSC_CTRL_INIT;
            rsp_r <= '0;
        end else begin
            flags_r <= flags_nxt;
            stack_fault_r <= stack_fault_nxt;
            summary_r <= summary_nxt;
            cc_r <= cc_nxt;
            top_r <= top_nxt;
            ctrl_r <= ctrl_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign rsp_o = rsp_r;
    assign status_word_o = status_w;
    assign control_word_o = ctrl_r;
    assign summary_o = summary_r;
endmodule
`default_nettype wire

/* dv/fpsc_int_unit_model.sv */
// Integer unit model: accumulator and integer flags fed by the block's answers
`default_nettype none
module fpsc_int_unit_model
    import fpsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic rsp_valid_i,
    input wire fpsc_pkg::fpsc_rsp_t rsp_i,
    output logic [15:0] acc_o,
    output logic [7:0] int_flags_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Enables count only with a valid answer; stale ones must not leak in
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            acc_o <= 16'h0000;
            int_flags_o <= 8'h00;
        end else if (rsp_valid_i) begin
            if (rsp_i.acc_we) acc_o <= rsp_i.acc;
            if (rsp_i.iflag_we) int_flags_o <= (int_flags_o & ~rsp_i.iflag_mask) |
                (rsp_i.iflag_val & rsp_i.iflag_mask);
        end
    end
endmodule
`default_nettype wire

/* dv/fpsc_status_ctrl_props.sv */
// Port-level checker of the status/control block
`default_nettype none
module fpsc_status_ctrl_props
    import fpsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire fpsc_pkg::fpsc_req_t req_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire fpsc_pkg::fpsc_rsp_t rsp_o,
    input wire logic [15:0] status_word_o,
    input wire logic [15:0] control_word_o,
    input wire logic summary_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Expected {C3,C2,C0} of a compare, kept apart from the design's encoder
    function automatic logic [2:0] cmp_cc(input fpsc_cmp_t c);
        return (c == FPSC_CMP_LT) ? 3'h1 : (c == FPSC_CMP_EQ) ? 3'h4 :
            (c == FPSC_CMP_UNORD) ? 3'h7 : 3'h0;
    endfunction

    // Steps of one request: taken, two busy cycles, then open again
    sequence take_s;
        req_valid_i && req_ready_o;
    endsequence
    sequence answer_s;
        !req_ready_o && !rsp_valid_o ##1 rsp_valid_o;
    endsequence
    sequence reopen_s;
        req_ready_o && !rsp_valid_o;
    endsequence

    answer_time_a: assert property (take_s |=> answer_s ##1 reopen_s)
        else $error("answer not two cycles after take");
    busy_mirror_a: assert property (status_word_o[15] == status_word_o[7])
        else $error("busy bit differs from summary");
    summary_calc_a: assert property (
        summary_o == status_word_o[7] &&
        summary_o == |(status_word_o[5:0] & ~control_word_o[5:0]))
        else $error("summary not equal to unmasked flags");
    sticky_flags_a: assert property (
        rsp_valid_o && !($past(req_i.op, 2) inside {FPSC_OP_CLEAR_EXC, FPSC_OP_INIT,
        FPSC_OP_SAVE, FPSC_OP_RESTORE, FPSC_OP_LOAD_ENV})
        |-> (($past(status_word_o, 2) & ~status_word_o & 16'h007f) == 16'h0000))
        else $error("flag or stack fault dropped");
    quiet_words_a: assert property (
        $changed(status_word_o) || $changed(control_word_o) |-> rsp_valid_o)
        else $error("word changed outside an answer");
    init_value_a: assert property (
        rsp_valid_o && $past(req_i.op, 2) inside {FPSC_OP_INIT, FPSC_OP_SAVE}
        |-> control_word_o == FPSC_CTRL_INIT && status_word_o == 16'h0000)
        else $error("init value wrong");
    store_acc_a: assert property (
        rsp_valid_o && $past(req_i.op, 2) == FPSC_OP_STORE_STATUS && $past(req_i.to_acc, 2)
        |-> rsp_o.acc_we && rsp_o.acc == $past(status_word_o, 2))
        else $error("accumulator copy wrong");
    fault_dir_a: assert property (
        rsp_valid_o && $past(req_i.stack_fault, 2)
        |-> status_word_o[6] && status_word_o[9] == $past(req_i.stack_ovf, 2))
        else $error("stack fault direction wrong");
    cc_compare_a: assert property (
        rsp_valid_o && $past(req_i.op, 2) == FPSC_OP_COMPARE && !$past(req_i.stack_fault, 2)
        |-> {status_word_o[14], status_word_o[10], status_word_o[8], status_word_o[9]}
        == {cmp_cc($past(req_i.cmp, 2)), 1'b0})
        else $error("compare condition bits wrong");
endmodule

bind fpsc_status_ctrl fpsc_status_ctrl_props fpsc_status_ctrl_props_inst (
    .sys_clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o,
    .status_word_o, .control_word_o, .summary_o
);
`default_nettype wire

/* dv/fpsc_status_ctrl_tb.sv */
// Self-checking bench of the status/control block
`default_nettype none
module fpsc_status_ctrl_tb;
    import fpsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    fpsc_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, summary_o;
    fpsc_rsp_t rsp_o;
    logic [15:0] status_word_o, control_word_o, acc, s0;
    logic [7:0] iflags;
    int n_mismatch = 0;
    int n_tests = 0;
    fpsc_req_t q;
    logic [2:0] cmpx [4] = '{3'b000, 3'b001, 3'b100, 3'b111};

    always #2 sys_clk_i = ~sys_clk_i;

    fpsc_status_ctrl fpsc_status_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .status_word_o(status_word_o),
        .control_word_o(control_word_o), .summary_o(summary_o));
    fpsc_int_unit_model fpsc_int_unit_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .acc_o(acc), .int_flags_o(iflags));

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Offer one request at a falling edge, wait bounded for its answer
    task automatic issue(input fpsc_req_t r);
        int k;
        `CHK(req_ready_o, 1'b1)
        req_i = r;
        req_valid_i = 1'b1;
        @(negedge sys_clk_i);
        req_valid_i = 1'b0;
        k = 0;
        while (rsp_valid_o !== 1'b1 && k < 8) begin
            @(negedge sys_clk_i);
            k++;
        end
        `CHK(k < 8, 1'b1)
        @(negedge sys_clk_i);
    endtask

    // Request with the integer unit's present state attached
    function automatic fpsc_req_t mk(input fpsc_op_t o, input logic [5:0] e);
        fpsc_req_t r;
        r = '0;
        r.op = o;
        r.exc = e;
        r.acc = acc;
        r.int_flags = iflags;
        return r;
    endfunction

    // Move decision: carry, zero, either, parity; top bit negates
    function automatic logic mv(input logic [2:0] c, input logic [7:0] f);
        logic t;
        case (c[1:0])
            2'h0: t = f[0];
            2'h1: t = f[6];
            2'h2: t = f[0] | f[6];
            default: t = f[2];
        endcase
        return t ^ c[2];
    endfunction

    initial begin
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'b0;
        `CHK({status_word_o, control_word_o}, {16'h0000, FPSC_CTRL_INIT})
        issue(mk(FPSC_OP_ARITH, 6'h04));
        `CHK(status_word_o[7:0], 8'h04)
        q = mk(FPSC_OP_LOAD_CTRL, 6'h00);
        q.img_ctrl = 16'h037b;
        issue(q);
        `CHK(control_word_o, 16'h037b)
        `CHK({status_word_o[15], summary_o, status_word_o[7]}, 3'b111)
        issue(mk(FPSC_OP_STORE_CTRL, 6'h00));
        `CHK({rsp_o.mem_ctrl_we, rsp_o.mem_ctrl}, {1'b1, 16'h037b})
        // Every compare outcome, its flag form, and all move conditions on it
        for (int i = 0; i < 4; i++) begin
            q = mk(FPSC_OP_COMPARE, 6'h00);
            q.cmp = fpsc_cmp_t'(i);
            issue(q);
            `CHK({status_word_o[14], status_word_o[10], status_word_o[8]}, cmpx[i])
            q.op = FPSC_OP_COMPARE_SET;
            issue(q);
            `CHK(rsp_o.iflag_mask, 8'h45)
            `CHK(iflags, {1'b0, cmpx[i][2], 3'h0, cmpx[i][1], 1'b0, cmpx[i][0]})
            for (int c = 0; c < 8; c++) begin
                q = mk(FPSC_OP_COND_MOVE, 6'h00);
                q.cond = fpsc_cond_t'(c);
                issue(q);
                `CHK(rsp_o.move_take, mv(3'(c), iflags))
            end
        end
        `CHK(status_word_o[5:0], 6'h04)
        s0 = status_word_o;
        q = mk(FPSC_OP_STORE_STATUS, 6'h00);
        q.to_acc = 1'b1;
        issue(q);
        `CHK(acc, s0)
        `CHK({rsp_o.acc_we, rsp_o.mem_status_we}, 2'b10)
        issue(mk(FPSC_OP_FLAGS_LOAD, 6'h00));
        `CHK(iflags, s0[15:8])
        q = mk(FPSC_OP_TRIG, 6'h00);
        // In range first: C2 is still set from the unordered compare
        for (int i = 0; i < 2; i++) begin
            q.range_err = 1'(i);
            issue(q);
            `CHK(status_word_o[10], 1'(i))
        end
        q = mk(FPSC_OP_PREM, 6'h00);
        q.quot = 3'b101;
        issue(q);
        `CHK({status_word_o[8], status_word_o[14], status_word_o[9], status_word_o[10]}, 4'b1010)
        q.reduce_incomplete = 1'b1;
        issue(q);
        `CHK(status_word_o[10], 1'b1)
        q = mk(FPSC_OP_ARITH, 6'h20);
        q.round_up = 1'b1;
        issue(q);
        `CHK({status_word_o[5], status_word_o[9]}, 2'b11)
        q = mk(FPSC_OP_EXAMINE, 6'h00);
        q.exam_class = 3'b101;
        q.exam_sign = 1'b1;
        q.top_we = 1'b1;
        q.top_val = 3'h5;
        issue(q);
        `CHK(status_word_o[14:8], 7'b1101011)
        // Overflow, then invalid-only, then underflow: fault stays set
        q = mk(FPSC_OP_ARITH, 6'h01);
        q.stack_fault = 1'b1;
        q.stack_ovf = 1'b1;
        issue(q);
        `CHK({status_word_o[6], status_word_o[9], status_word_o[0]}, 3'b111)
        issue(mk(FPSC_OP_ARITH, 6'h01));
        `CHK(status_word_o[6], 1'b1)
        q.stack_ovf = 1'b0;
        // A rounded-up result would give C1 = 1; the fault direction must override it
        q.exc = 6'h21;
        q.round_up = 1'b1;
        issue(q);
        `CHK(status_word_o[9], 1'b0)
        issue(mk(FPSC_OP_CLEAR_EXC, 6'h00));
        `CHK({summary_o, status_word_o[7:0]}, 9'h000)
        for (int i = 0; i < 2; i++) begin
            q = mk(i ? FPSC_OP_LOAD_ENV : FPSC_OP_RESTORE, 6'h00);
            q.img_status = i ? 16'h3a41 : 16'h4524;
            q.img_ctrl = 16'h037b;
            issue(q);
            `CHK(control_word_o, 16'h037b)
            `CHK(status_word_o & 16'h7f7f, q.img_status & 16'h7f7f)
        end
        s0 = status_word_o;
        issue(mk(FPSC_OP_SAVE, 6'h00));
        `CHK({rsp_o.mem_status, rsp_o.mem_ctrl}, {s0, 16'h037b})
        `CHK({rsp_o.mem_status_we, rsp_o.mem_ctrl_we}, 2'b11)
        `CHK({status_word_o, control_word_o}, {16'h0000, FPSC_CTRL_INIT})
        issue(mk(FPSC_OP_ARITH, 6'h3f));
        `CHK({summary_o, status_word_o[5:0]}, 7'h3f)
        issue(mk(FPSC_OP_INIT, 6'h00));
        `CHK({status_word_o, control_word_o}, {16'h0000, FPSC_CTRL_INIT})
        finish_test();
    end

    // About 60 requests of three cycles each; this bound leaves wide margin
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
